// File: mp3_decoder_aux_registers.sv
`timescale 1ns/1ps
module mp3_decoder_aux_registers #(
  parameter int ADDR_W = 10
) (
  input  wire logic              clk_sys,     // 50 MHz system clock
  input  wire logic              nrst,        // Async reset, active low
  input  wire logic              psel,        // APB select
  input  wire logic              penable,     // APB access phase
  input  wire logic              pwrite,      // APB direction
  input  wire logic [ADDR_W-1:0] paddr,       // APB byte address
  input  wire logic [31:0]       pwdata,      // APB write data
  output logic      [31:0]       prdata,      // APB read data
  output logic                   pready,      // APB ready
  output logic                   pslverr,     // APB error
  input  wire logic              frameReady,  // Decoder takes a new frame
  input  wire logic              byteNeed,    // Decoder wants a byte, pulse
  input  wire logic              ancNotEmpty, // Ancillary buffer has data
  input  wire logic [7:0]        ancHead,     // Head of ancillary buffer
  input  wire logic              sampleTick,  // Output sample boundary
  output logic                   ancPop,      // Ancillary byte consumed
  output logic      [7:0]        streamData,  // Stream byte to decoder
  output logic                   streamValid, // Stream byte strobe
  output logic      [4:0]        leftVolume,  // Applied left volume
  output logic      [4:0]        rightVolume, // Applied right volume
  output logic      [4:0]        lowBandGain, // Applied bass gain
  output logic      [4:0]        midBandGain, // Applied mid gain
  output logic      [4:0]        highBandGain,// Applied treble gain
  output logic                   irq          // Interrupt, level
);

  // ==========================================================
  // Bus decode
  logic [7:0] idx;
  logic       setupAcc;
  logic       doneAcc;
  logic       wrDone;
  logic       rdDone;
  logic       mapped;
  logic [7:0] rdMux;

  assign idx      = paddr[9:2];
  assign setupAcc = psel & penable & ~pready;
  assign doneAcc  = psel & penable & pready;
  assign wrDone   = doneAcc & pwrite & ~pslverr;
  assign rdDone   = doneAcc & ~pwrite & ~pslverr;

  always_comb begin
    mapped = 1'b0;
    case (idx)
      aux_regs_pkg::LEFT_VOLUME_IDX, aux_regs_pkg::RIGHT_VOLUME_IDX,
      aux_regs_pkg::STREAM_INPUT_IDX, aux_regs_pkg::ANCILLARY_IDX,
      aux_regs_pkg::REQUEST_STAT_IDX, aux_regs_pkg::LOW_BAND_IDX,
      aux_regs_pkg::MID_BAND_IDX, aux_regs_pkg::HIGH_BAND_IDX,
      aux_regs_pkg::MAIN_STAT_IDX, aux_regs_pkg::IRQ_STAT_IDX,
      aux_regs_pkg::IRQ_MASK_IDX: mapped = (paddr[1:0] == 2'h0);
      default: mapped = 1'b0;
    endcase
  end

  // ==========================================================
  // Software settings
  logic [4:0] leftVol_q;
  logic [4:0] rightVol_q;
  logic [4:0] lowGain_q;
  logic [4:0] midGain_q;
  logic [4:0] highGain_q;
  logic [2:0] irqMask_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      leftVol_q  <= aux_regs_pkg::FIELD_RST;
      rightVol_q <= aux_regs_pkg::FIELD_RST;
      lowGain_q  <= aux_regs_pkg::FIELD_RST;
      midGain_q  <= aux_regs_pkg::FIELD_RST;
      highGain_q <= aux_regs_pkg::FIELD_RST;
      irqMask_q  <= aux_regs_pkg::IRQ_MASK_RST;
    end else if (wrDone) begin
      case (idx)
        aux_regs_pkg::LEFT_VOLUME_IDX:  leftVol_q  <= pwdata[4:0];
        aux_regs_pkg::RIGHT_VOLUME_IDX: rightVol_q <= pwdata[4:0];
        aux_regs_pkg::LOW_BAND_IDX:     lowGain_q  <= pwdata[4:0];
        aux_regs_pkg::MID_BAND_IDX:     midGain_q  <= pwdata[4:0];
        aux_regs_pkg::HIGH_BAND_IDX:    highGain_q <= pwdata[4:0];
        aux_regs_pkg::IRQ_MASK_IDX:     irqMask_q  <= pwdata[2:0];
        default: irqMask_q <= irqMask_q;
      endcase
    end
  end

  // ==========================================================
  // Applied settings
  // sample aligned
  // Copies move only on a sample tick so a sample is never split
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      leftVolume   <= aux_regs_pkg::FIELD_RST;
      rightVolume  <= aux_regs_pkg::FIELD_RST;
      lowBandGain  <= aux_regs_pkg::FIELD_RST;
      midBandGain  <= aux_regs_pkg::FIELD_RST;
      highBandGain <= aux_regs_pkg::FIELD_RST;
    end else if (sampleTick) begin
      leftVolume   <= leftVol_q;
      rightVolume  <= rightVol_q;
      lowBandGain  <= lowGain_q;
      midBandGain  <= midGain_q;
      highBandGain <= highGain_q;
    end
  end

  // ==========================================================
  // Request flags
  logic frameFlag_q;
  logic byteFlag_q;
  logic resetMark_q;
  logic streamWr;

  assign streamWr = wrDone & (idx == aux_regs_pkg::STREAM_INPUT_IDX);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      frameFlag_q <= aux_regs_pkg::REQUEST_STAT_RST[4];
      resetMark_q <= aux_regs_pkg::REQUEST_STAT_RST[0];
    end else begin
      frameFlag_q <= frameReady;
      if (streamWr) begin
        resetMark_q <= 1'b0;
      end
    end
  end

  // byte request
  // A new request in the clearing cycle wins
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      byteFlag_q <= aux_regs_pkg::REQUEST_STAT_RST[3];
    end else if (byteNeed) begin
      byteFlag_q <= 1'b1;
    end else if (streamWr) begin
      byteFlag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      streamData  <= 8'h00;
      streamValid <= 1'b0;
    end else begin
      streamValid <= streamWr;
      if (streamWr) begin
        streamData <= pwdata[7:0];
      end
    end
  end

  // ==========================================================
  // Ancillary data
  logic [7:0] ancByte_q;
  logic       ancAvail_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ancByte_q  <= aux_regs_pkg::ANCILLARY_RST;
      ancAvail_q <= 1'b0;
      ancPop     <= 1'b0;
    end else begin
      ancByte_q  <= ancHead;
      ancAvail_q <= ancNotEmpty;
      ancPop     <= rdDone & ancAvail_q
                    & (idx == aux_regs_pkg::ANCILLARY_IDX);
    end
  end

  // ==========================================================
  // Interrupts
  logic [2:0] irqStat_q;
  logic [2:0] evSet;
  logic       frameFlagOld_q;
  logic       ancAvailOld_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      // Matches the flag's reset level, so no false rise follows reset
      frameFlagOld_q <= aux_regs_pkg::REQUEST_STAT_RST[4];
      ancAvailOld_q  <= 1'b0;
    end else begin
      frameFlagOld_q <= frameFlag_q;
      ancAvailOld_q  <= ancAvail_q;
    end
  end

  always_comb begin
    evSet = '0;
    evSet[aux_regs_pkg::EV_BYTE_BIT]  = byteNeed;
    evSet[aux_regs_pkg::EV_FRAME_BIT] = frameFlag_q & ~frameFlagOld_q;
    evSet[aux_regs_pkg::EV_ANC_BIT]   = ancAvail_q & ~ancAvailOld_q;
  end

  // Set beats a simultaneous write-one clear
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irqStat_q <= 3'h0;
    end else if (wrDone && idx == aux_regs_pkg::IRQ_STAT_IDX) begin
      irqStat_q <= (irqStat_q & ~pwdata[2:0]) | evSet;
    end else begin
      irqStat_q <= irqStat_q | evSet;
    end
  end

  logic irqPend;

  assign irqPend = |(irqStat_q & ~irqMask_q);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= irqPend;
    end
  end

  // ==========================================================
  // Read mux and APB handshake
  // reserved zero
  always_comb begin
    rdMux = 8'h00;
    case (idx)
      aux_regs_pkg::LEFT_VOLUME_IDX:  rdMux = {3'h0, leftVol_q};
      aux_regs_pkg::RIGHT_VOLUME_IDX: rdMux = {3'h0, rightVol_q};
      aux_regs_pkg::LOW_BAND_IDX:     rdMux = {3'h0, lowGain_q};
      aux_regs_pkg::MID_BAND_IDX:     rdMux = {3'h0, midGain_q};
      aux_regs_pkg::HIGH_BAND_IDX:    rdMux = {3'h0, highGain_q};
      aux_regs_pkg::ANCILLARY_IDX:    rdMux = ancByte_q;
      aux_regs_pkg::REQUEST_STAT_IDX:
        rdMux = {3'h0, frameFlag_q, byteFlag_q, 2'h0, resetMark_q};
      aux_regs_pkg::MAIN_STAT_IDX:    rdMux = {ancAvail_q, 7'h00};
      aux_regs_pkg::IRQ_STAT_IDX:     rdMux = {5'h00, irqStat_q};
      aux_regs_pkg::IRQ_MASK_IDX:     rdMux = {5'h00, irqMask_q};
      default:                        rdMux = 8'h00;
    endcase
  end

  // One wait state keeps all bus outputs registered
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setupAcc;
      pslverr <= setupAcc & ~mapped;
      if (setupAcc && !pwrite) begin
        prdata <= {24'h0, rdMux & {8{mapped}}};
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // reserved bits
  // Writes leave prdata as it was, so only read answers are judged
  rsvd_zero_a: assert property (pready && !pwrite |->
    prdata[31:8] == 24'h0 &&
    ($past(idx) != aux_regs_pkg::REQUEST_STAT_IDX || prdata[2:1] == 2'h0))
    else $error("reserved read bits not zero");
  byte_set_a: assert property (byteNeed |=> byteFlag_q)
    else $error("byte request not flagged");
  byte_clr_a: assert property (streamWr && !byteNeed |=>
    !byteFlag_q && streamValid && streamData == $past(pwdata[7:0]))
    else $error("stream write did not clear byte request");
  reset_pat_a: assert property ($rose(nrst) |->
    frameFlag_q && resetMark_q && !byteFlag_q)
    else $error("request status reset pattern wrong");
  anc_view_a: assert property (##1 ancByte_q == $past(ancHead))
    else $error("ancillary byte not tracking buffer head");
  anc_avail_a: assert property (ancNotEmpty != ancAvail_q |=>
    ancAvail_q == $past(ancNotEmpty))
    else $error("ancillary available flag stale");
  frame_follow_a: assert property (
    ##1 frameFlag_q == $past(frameReady))
    else $error("frame request not following readiness");
  vol_write_a: assert property (wrDone &&
    idx == aux_regs_pkg::LEFT_VOLUME_IDX |=> leftVol_q == $past(pwdata[4:0]))
    else $error("left volume write lost");
  apply_hold_a: assert property (!sampleTick |=>
    $stable(leftVolume) && $stable(highBandGain) && $stable(rightVolume) &&
    $stable(lowBandGain) && $stable(midBandGain))
    else $error("setting changed between samples");
  // Irq level
  irq_level_a: assert property (##1 irq == $past(irqPend))
    else $error("interrupt output wrong");

  stream_wr_c: cover property (byteFlag_q ##1 streamWr ##1 !byteFlag_q);
  anc_read_c: cover property (rdDone && idx == aux_regs_pkg::ANCILLARY_IDX
    && ancAvail_q);
  irq_c: cover property ($rose(irq));
  err_c: cover property (pready && pslverr);

endmodule

// File: aux_regs_pkg.sv
package aux_regs_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [7:0] LEFT_VOLUME_IDX   = 8'h9e;
  localparam logic [7:0] RIGHT_VOLUME_IDX  = 8'h9f;
  localparam logic [7:0] STREAM_INPUT_IDX  = 8'hac;
  localparam logic [7:0] ANCILLARY_IDX     = 8'had;
  localparam logic [7:0] REQUEST_STAT_IDX  = 8'haf;
  localparam logic [7:0] LOW_BAND_IDX      = 8'hb4;
  localparam logic [7:0] MID_BAND_IDX      = 8'hb5;
  localparam logic [7:0] HIGH_BAND_IDX     = 8'hb6;
  localparam logic [7:0] MAIN_STAT_IDX     = 8'hc8;
  localparam logic [7:0] IRQ_STAT_IDX      = 8'hf0;
  localparam logic [7:0] IRQ_MASK_IDX      = 8'hf1;
  // Field positions
  localparam int FIELD_W        = 5;
  localparam int FRAME_REQ_BIT  = 4;
  localparam int BYTE_REQ_BIT   = 3;
  localparam int RESET_MARK_BIT = 0;
  localparam int ANC_AVAIL_BIT  = 7;
  localparam int EV_BYTE_BIT    = 0;
  localparam int EV_FRAME_BIT   = 1;
  localparam int EV_ANC_BIT     = 2;
  localparam int EV_W           = 3;
  // Reset values
  localparam logic [7:0] REQUEST_STAT_RST = 8'h11;
  localparam logic [4:0] FIELD_RST        = 5'h00;
  localparam logic [7:0] ANCILLARY_RST    = 8'h00;
  localparam logic [2:0] IRQ_MASK_RST     = 3'h7;
endpackage

// File: test_mp3_decoder_aux_registers.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  totalChecks++; \
  if ((got) !== (exp)) begin \
    errorCnt++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); \
  end \
end

module test_mp3_decoder_aux_registers;
  logic        clk_sys;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [9:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        frameReady;
  logic        byteNeed;
  logic        ancNotEmpty;
  logic [7:0]  ancHead;
  logic        sampleTick;
  logic        ancPop;
  logic [7:0]  streamData;
  logic        streamValid;
  logic [4:0]  leftVolume;
  logic [4:0]  rightVolume;
  logic [4:0]  lowBandGain;
  logic [4:0]  midBandGain;
  logic [4:0]  highBandGain;
  logic        irq;
  int          errorCnt;
  int          totalChecks;
  int          svCnt;
  int          popCnt;
  logic [31:0] rdat;
  logic        rerr;

  mp3_decoder_aux_registers mp3_decoder_aux_registers_inst (
    .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frameReady(frameReady),
    .byteNeed(byteNeed), .ancNotEmpty(ancNotEmpty), .ancHead(ancHead),
    .sampleTick(sampleTick), .ancPop(ancPop), .streamData(streamData),
    .streamValid(streamValid), .leftVolume(leftVolume),
    .rightVolume(rightVolume), .lowBandGain(lowBandGain),
    .midBandGain(midBandGain), .highBandGain(highBandGain), .irq(irq));

  always #10 clk_sys = ~clk_sys;

  // Pulse counters, so strobe checks do not depend on exact latency
  always @(posedge clk_sys) begin
    if (streamValid === 1'b1) svCnt++;
    if (ancPop === 1'b1) popCnt++;
  end

  // ==========================================================
  // Bus and helper tasks
  task give_verdict();
    if (errorCnt == 0 && totalChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Ends one edge after release so the next call never reassigns psel
  task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errorCnt++;
      give_verdict();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task rdchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    `CHK(rdat, exp)
  endtask

  // ==========================================================
  // Scenarios
  task reset_values();
    rdchk(aux_regs_pkg::REQUEST_STAT_IDX, 32'h00000011);
    rdchk(aux_regs_pkg::ANCILLARY_IDX, 32'h00000000);
    rdchk(aux_regs_pkg::RIGHT_VOLUME_IDX, 32'h00000000);
    rdchk(aux_regs_pkg::LOW_BAND_IDX, 32'h00000000);
    rdchk(aux_regs_pkg::HIGH_BAND_IDX, 32'h00000000);
    apb(1'b0, 8'h01, 8'h00);
    `CHK(rerr, 1'b1)
    `CHK(rdat, 32'h00000000)
  endtask

  task settings();
    logic [7:0] idx [5];
    logic [4:0] val [5];
    idx = '{aux_regs_pkg::LEFT_VOLUME_IDX, aux_regs_pkg::RIGHT_VOLUME_IDX,
            aux_regs_pkg::LOW_BAND_IDX, aux_regs_pkg::MID_BAND_IDX,
            aux_regs_pkg::HIGH_BAND_IDX};
    val = '{5'h1f, 5'h0a, 5'h15, 5'h01, 5'h10};
    // Only field bits are written; reserved bits stay zero
    for (int i = 0; i < 5; i++) apb(1'b1, idx[i], {3'h0, val[i]});
    for (int i = 0; i < 5; i++) rdchk(idx[i], {27'h0, val[i]});
    tick(3);
    `CHK(leftVolume, 5'h00)
    sampleTick <= 1'b1;
    @(posedge clk_sys);
    sampleTick <= 1'b0;
    tick(3);
    `CHK({leftVolume, rightVolume, lowBandGain}, {5'h1f, 5'h0a, 5'h15})
    `CHK({midBandGain, highBandGain}, {5'h01, 5'h10})
  endtask

  task byte_request();
    int sv;
    byteNeed <= 1'b1;
    @(posedge clk_sys);
    byteNeed <= 1'b0;
    tick(3);
    rdchk(aux_regs_pkg::REQUEST_STAT_IDX, 32'h00000019);
    `CHK(irq, 1'b0)
    apb(1'b1, aux_regs_pkg::IRQ_MASK_IDX, 8'h06);
    tick(3);
    `CHK(irq, 1'b1)
    sv = svCnt;
    apb(1'b1, aux_regs_pkg::STREAM_INPUT_IDX, 8'h5a);
    tick(3);
    `CHK(svCnt, sv + 1)
    `CHK(streamData, 8'h5a)
    rdchk(aux_regs_pkg::REQUEST_STAT_IDX, 32'h00000010);
    apb(1'b1, aux_regs_pkg::IRQ_STAT_IDX, 8'h01);
    tick(3);
    `CHK(irq, 1'b0)
  endtask

  task frame_flag();
    frameReady <= 1'b0;
    tick(3);
    rdchk(aux_regs_pkg::REQUEST_STAT_IDX, 32'h00000000);
    frameReady <= 1'b1;
    tick(3);
    rdchk(aux_regs_pkg::REQUEST_STAT_IDX, 32'h00000010);
    rdchk(aux_regs_pkg::IRQ_STAT_IDX, 32'h00000002);
  endtask

  task ancillary();
    int pc;
    ancHead <= 8'ha5;
    ancNotEmpty <= 1'b1;
    tick(3);
    rdchk(aux_regs_pkg::MAIN_STAT_IDX, 32'h00000080);
    apb(1'b1, aux_regs_pkg::IRQ_MASK_IDX, 8'h03);
    tick(3);
    `CHK(irq, 1'b1)
    rdchk(aux_regs_pkg::IRQ_STAT_IDX, 32'h00000006);
    apb(1'b1, aux_regs_pkg::ANCILLARY_IDX, 8'h00);
    pc = popCnt;
    rdchk(aux_regs_pkg::ANCILLARY_IDX, 32'h000000a5);
    tick(2);
    `CHK(popCnt, pc + 1)
    ancNotEmpty <= 1'b0;
    tick(3);
    rdchk(aux_regs_pkg::MAIN_STAT_IDX, 32'h00000000);
  endtask

  initial begin
    clk_sys = 1'b0;
    nrst = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {byteNeed, ancNotEmpty, ancHead, sampleTick} = '0;
    frameReady = 1'b1;
    errorCnt = 0;
    totalChecks = 0;
    svCnt = 0;
    popCnt = 0;
    tick(2);
    nrst <= 1'b1;
    @(posedge clk_sys);
    reset_values();
    settings();
    byte_request();
    frame_flag();
    ancillary();
    give_verdict();
  end
endmodule
